// ===== verilog/timer_pkg.sv
// Purpose: Shared constants and carrier types of the periodic timer.
// Assumes: 32-bit APB data, byte offsets within a 4 KiB window.
// Notes: Counter registers repeat with a fixed stride per counter.
package timer_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int NUM_COUNTER = 2;
	localparam int NUM_COMPARE = 4;
	localparam int NUM_CAPTURE = 2;
	localparam int NUM_DMA_EVENTS = 6;
	localparam int NUM_INT = 6;

	// Register byte offsets
	localparam logic [11:0] OFS_GLOBAL_CTRL = 12'h000;
	localparam logic [11:0] OFS_CAPTURE_CTRL = 12'h008;
	localparam logic [11:0] OFS_COMPARE_CTRL = 12'h00C;
	localparam logic [11:0] OFS_CNT_BASE = 12'h010;
	localparam logic [11:0] OFS_CNT_STRIDE = 12'h020;
	localparam logic [11:0] OFS_FREE_RUN = 12'h000;
	localparam logic [11:0] OFS_PRESCALE_CNT = 12'h004;
	localparam logic [11:0] OFS_PRESCALE_CMP = 12'h008;
	localparam logic [11:0] OFS_CAPT_FREE = 12'h010;
	localparam logic [11:0] OFS_CAPT_PRESCALE = 12'h014;
	localparam logic [11:0] OFS_COMPARE_BASE = 12'h050;
	localparam logic [11:0] OFS_INCREMENT_BASE = 12'h054;
	localparam logic [11:0] OFS_COMPARE_STRIDE = 12'h008;
	localparam logic [11:0] OFS_INT_SET = 12'h080;
	localparam logic [11:0] OFS_INT_CLEAR = 12'h084;
	localparam logic [11:0] OFS_INT_FLAG = 12'h088;
	localparam logic [11:0] OFS_WD_CTRL = 12'h090;
	localparam logic [11:0] OFS_WD_PRELOAD = 12'h094;
	localparam logic [11:0] OFS_WD_STATUS = 12'h098;
	localparam logic [11:0] OFS_WD_KEY = 12'h09C;
	localparam logic [11:0] OFS_WD_COUNT = 12'h0A0;
	localparam logic [11:0] OFS_CAPTURE_SOURCE = 12'h0B0;

	// Field positions
	localparam int CAPSEL0_LSB = 0;
	localparam int CAPSEL1_LSB = 4;
	localparam int CAPSEL_W = 3;
	localparam int COMPARE_SEL_STRIDE = 4;
	localparam int INT_CAPT_LSB = 4;
	localparam int WD_STAT_EXPIRED = 0;
	localparam int WD_STAT_ENABLED = 1;

	// Watchdog key pair and reset values
	localparam logic [15:0] WD_KEY_FIRST = 16'hE51A;
	localparam logic [15:0] WD_KEY_SECOND = 16'hA35C;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_WD_PRELOAD = 32'h0000_FFFF;

	// Watchdog key sequence states
	typedef enum logic [1:0] {
		KEY_WAIT_FIRST = 2'b01,
		KEY_WAIT_SECOND = 2'b10
	} key_state_e;

	// Control going into one counter
	typedef struct packed {
		logic run;
		logic wr_free;
		logic wr_prescale;
		logic wr_prescale_cmp;
		logic capture;
		logic [DATA_W-1:0] wdata;
	} cnt_ctrl_s;

	// State coming out of one counter
	typedef struct packed {
		logic tick;
		logic [DATA_W-1:0] free_run;
		logic [DATA_W-1:0] prescale;
		logic [DATA_W-1:0] prescale_cmp;
		logic [DATA_W-1:0] capt_free;
		logic [DATA_W-1:0] capt_prescale;
	} cnt_stat_s;
endpackage : timer_pkg

// ===== verilog/prescale_counter.sv
// Purpose: One prescaled free-running counter with capture registers.
// Assumes: Control strobes are one-cycle pulses in the clock domain.
// Notes: Tick marks the cycle in which the new free-running value shows.
`timescale 1ns/1ps
`default_nettype none
module prescale_counter import timer_pkg::*; #(
	parameter int CNT_W = DATA_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control and state
	input wire cnt_ctrl_s ctrl_i,
	output cnt_stat_s stat_o
);
	generate
		if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_width
			$error("prescale_counter: CNT_W out of range");
		end
	endgenerate

	logic [CNT_W-1:0] free_cnt, next_free_cnt;
	logic [CNT_W-1:0] pre_cnt, next_pre_cnt;
	logic [CNT_W-1:0] pre_cmp, next_pre_cmp;
	logic [CNT_W-1:0] capt_free, next_capt_free;
	logic [CNT_W-1:0] capt_pre, next_capt_pre;
	logic tick, next_tick;

	// Prescale, count, software writes and capture
	always_comb begin
		next_free_cnt = free_cnt;
		next_pre_cnt = pre_cnt;
		next_pre_cmp = pre_cmp;
		next_capt_free = capt_free;
		next_capt_pre = capt_pre;
		next_tick = 1'b0;
		if (ctrl_i.run) begin
			// >= so a lowered compare cannot strand the prescaler
			if (pre_cnt >= pre_cmp) begin
				next_pre_cnt = '0;
				next_free_cnt = free_cnt + 1'b1;
				next_tick = 1'b1;
			end else begin
				next_pre_cnt = pre_cnt + 1'b1;
			end
		end
		if (ctrl_i.wr_free) next_free_cnt = ctrl_i.wdata[CNT_W-1:0];
		if (ctrl_i.wr_prescale) next_pre_cnt = ctrl_i.wdata[CNT_W-1:0];
		if (ctrl_i.wr_prescale_cmp) next_pre_cmp = ctrl_i.wdata[CNT_W-1:0];
		if (ctrl_i.capture) begin
			next_capt_free = free_cnt;
			next_capt_pre = pre_cnt;
		end
	end

	// Register stage
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			free_cnt <= '0;
			pre_cnt <= '0;
			pre_cmp <= '0;
			capt_free <= '0;
			capt_pre <= '0;
			tick <= 1'b0;
		end else begin
			free_cnt <= next_free_cnt;
			pre_cnt <= next_pre_cnt;
			pre_cmp <= next_pre_cmp;
			capt_free <= next_capt_free;
			capt_pre <= next_capt_pre;
			tick <= next_tick;
		end
	end

	// Zero-extended view for the register file
	assign stat_o.tick = tick;
	assign stat_o.free_run = DATA_W'(free_cnt);
	assign stat_o.prescale = DATA_W'(pre_cnt);
	assign stat_o.prescale_cmp = DATA_W'(pre_cmp);
	assign stat_o.capt_free = DATA_W'(capt_free);
	assign stat_o.capt_prescale = DATA_W'(capt_pre);
endmodule : prescale_counter
`default_nettype wire

// ===== verilog/periodic_interrupt_timer.sv
// Purpose: Periodic interrupt timer with digital watchdog, APB slave.
// Assumes: CLK_I is the divided system clock; DMA events are synchronous.
// Notes: Watchdog reset output stays high until the block is reset.
// Functional notes
// - Two independent counters, both advanced by the one divided system clock.
// - Each counter has its own start bit and its own prescale ratio.
// - Four compare units watch the counters and raise periodic interrupts.
// - Compare value advances by its period after each interrupt automatically.
// - Two captures, each triggered by a selectable audio port DMA event.
// - Watchdog stays inactive after reset until software enables it.
// - Enabled watchdog reaching zero without a full key pair resets processor.
// - On a match each compare adds its increment register to its value.
// - Interrupt enables change via separate set and clear registers.
// - Capture stores free-running and prescale values of the chosen counter.
// - A preload register gives the watchdog down-counter its start value.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module periodic_interrupt_timer import timer_pkg::*; (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [DATA_W-1:0] PWDATA_I,
	output logic [DATA_W-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Capture triggers from the audio serial port DMA requests
	input wire logic [NUM_DMA_EVENTS-1:0] DMA_EVENT_I,
	// Interrupt and processor reset request
	output logic IRQ_O,
	output logic WD_RESET_O
);
	// Address match helper used by the write decoders and the counter and compare reads
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction : hit

	// Capture trigger pick; codes beyond the event count select nothing
	function automatic logic pick_event(input logic [CAPSEL_W-1:0] sel,
		input logic [NUM_DMA_EVENTS-1:0] ev);
		pick_event = 1'b0;
		if (int'(sel) < NUM_DMA_EVENTS) pick_event = ev[sel];
	endfunction : pick_event

	logic wr_en;
	logic [DATA_W-1:0] rd_mux;
	logic rd_ok;
	cnt_ctrl_s cnt_ctrl [NUM_COUNTER];
	cnt_stat_s cnt_stat [NUM_COUNTER];
	logic [NUM_CAPTURE-1:0] cap_trig;
	logic [NUM_COMPARE-1:0] cmp_match;

	// Configuration state
	logic [NUM_COUNTER-1:0] run, next_run;
	logic [NUM_CAPTURE-1:0] cap_cnt_sel, next_cap_cnt_sel;
	logic [NUM_COMPARE-1:0] cmp_cnt_sel, next_cmp_cnt_sel;
	logic [2*CAPSEL_W-1:0] cap_src, next_cap_src;
	logic [NUM_DMA_EVENTS-1:0] dma_prev;
	// Compare state
	logic [DATA_W-1:0] cmp_val [NUM_COMPARE];
	logic [DATA_W-1:0] next_cmp_val [NUM_COMPARE];
	logic [DATA_W-1:0] cmp_inc [NUM_COMPARE];
	logic [DATA_W-1:0] next_cmp_inc [NUM_COMPARE];
	// Interrupt state
	logic [NUM_INT-1:0] int_en, next_int_en;
	logic [NUM_INT-1:0] int_flag, next_int_flag;
	logic next_irq;
	// Watchdog state
	logic wd_en, next_wd_en;
	logic wd_expired, next_wd_expired;
	logic [DATA_W-1:0] wd_preload, next_wd_preload;
	logic [DATA_W-1:0] wd_count, next_wd_count;
	key_state_e key_state, next_key_state;
	// Bus answer state
	logic [DATA_W-1:0] next_prdata;
	logic next_pready, next_pslverr;

	// Writes land only at the completing access edge
	assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;

	// Counters and their register strobes
	generate
		for (genvar c = 0; c < NUM_COUNTER; c++) begin : g_cnt
			localparam logic [11:0] BASE =
				12'(OFS_CNT_BASE + OFS_CNT_STRIDE * c);
			logic cap_any;
			always_comb begin
				cap_any = 1'b0;
				for (int k = 0; k < NUM_CAPTURE; k++) begin
					if (cap_trig[k] && (int'(cap_cnt_sel[k]) == c)) cap_any = 1'b1;
				end
			end
			assign cnt_ctrl[c].run = run[c];
			assign cnt_ctrl[c].wr_free = wr_en && hit(PADDR_I, BASE + OFS_FREE_RUN);
			assign cnt_ctrl[c].wr_prescale =
				wr_en && hit(PADDR_I, BASE + OFS_PRESCALE_CNT);
			assign cnt_ctrl[c].wr_prescale_cmp =
				wr_en && hit(PADDR_I, BASE + OFS_PRESCALE_CMP);
			assign cnt_ctrl[c].capture = cap_any;
			assign cnt_ctrl[c].wdata = PWDATA_I;
			// Same clock for both counters keeps them phase-related
			prescale_counter #(.CNT_W(DATA_W)) u_cnt (
				.clk_i(CLK_I),
				.arst_n_i(ARST_N_I),
				.ctrl_i(cnt_ctrl[c]),
				.stat_o(cnt_stat[c])
			);
		end
	endgenerate

	// Capture triggers on the rising edge of the selected DMA event
	assign cap_trig[0] = pick_event(cap_src[CAPSEL0_LSB +: CAPSEL_W],
		DMA_EVENT_I & ~dma_prev);
	assign cap_trig[1] = pick_event(cap_src[CAPSEL_W +: CAPSEL_W],
		DMA_EVENT_I & ~dma_prev);

	// Configuration registers
	always_comb begin
		next_run = run;
		next_cap_cnt_sel = cap_cnt_sel;
		next_cmp_cnt_sel = cmp_cnt_sel;
		next_cap_src = cap_src;
		if (wr_en && hit(PADDR_I, OFS_GLOBAL_CTRL)) begin
			next_run = PWDATA_I[NUM_COUNTER-1:0];
		end
		if (wr_en && hit(PADDR_I, OFS_CAPTURE_CTRL)) begin
			next_cap_cnt_sel = PWDATA_I[NUM_CAPTURE-1:0];
		end
		if (wr_en && hit(PADDR_I, OFS_COMPARE_CTRL)) begin
			for (int i = 0; i < NUM_COMPARE; i++) begin
				next_cmp_cnt_sel[i] = PWDATA_I[i*COMPARE_SEL_STRIDE];
			end
		end
		if (wr_en && hit(PADDR_I, OFS_CAPTURE_SOURCE)) begin
			next_cap_src = {PWDATA_I[CAPSEL1_LSB +: CAPSEL_W],
				PWDATA_I[CAPSEL0_LSB +: CAPSEL_W]};
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			run <= '0;
			cap_cnt_sel <= '0;
			cmp_cnt_sel <= '0;
			cap_src <= '0;
			dma_prev <= '0;
		end else begin
			run <= next_run;
			cap_cnt_sel <= next_cap_cnt_sel;
			cmp_cnt_sel <= next_cmp_cnt_sel;
			cap_src <= next_cap_src;
			dma_prev <= DMA_EVENT_I;
		end
	end

	// Compare units: match on the cycle the new count shows
	always_comb begin
		for (int i = 0; i < NUM_COMPARE; i++) begin
			cmp_match[i] = cnt_stat[cmp_cnt_sel[i]].tick &&
				(cnt_stat[cmp_cnt_sel[i]].free_run == cmp_val[i]);
			next_cmp_val[i] = cmp_val[i];
			next_cmp_inc[i] = cmp_inc[i];
			if (cmp_match[i]) next_cmp_val[i] = cmp_val[i] + cmp_inc[i];
			// Software write wins over the automatic step
			if (wr_en && hit(PADDR_I, 12'(OFS_COMPARE_BASE +
				OFS_COMPARE_STRIDE * i))) next_cmp_val[i] = PWDATA_I;
			if (wr_en && hit(PADDR_I, 12'(OFS_INCREMENT_BASE +
				OFS_COMPARE_STRIDE * i))) next_cmp_inc[i] = PWDATA_I;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int i = 0; i < NUM_COMPARE; i++) begin
				cmp_val[i] <= RST_ZERO;
				cmp_inc[i] <= RST_ZERO;
			end
		end else begin
			for (int i = 0; i < NUM_COMPARE; i++) begin
				cmp_val[i] <= next_cmp_val[i];
				cmp_inc[i] <= next_cmp_inc[i];
			end
		end
	end

	// Interrupt flags and enables; a new event beats a same-cycle clear
	always_comb begin
		next_int_en = int_en;
		if (wr_en && hit(PADDR_I, OFS_INT_SET)) begin
			next_int_en = int_en | PWDATA_I[NUM_INT-1:0];
		end
		if (wr_en && hit(PADDR_I, OFS_INT_CLEAR)) begin
			next_int_en = int_en & ~PWDATA_I[NUM_INT-1:0];
		end
		next_int_flag = int_flag;
		if (wr_en && hit(PADDR_I, OFS_INT_FLAG)) begin
			next_int_flag = int_flag & ~PWDATA_I[NUM_INT-1:0];
		end
		next_int_flag[NUM_COMPARE-1:0] = next_int_flag[NUM_COMPARE-1:0] |
			cmp_match;
		next_int_flag[INT_CAPT_LSB +: NUM_CAPTURE] =
			next_int_flag[INT_CAPT_LSB +: NUM_CAPTURE] | cap_trig;
		next_irq = |(next_int_flag & next_int_en);
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			int_en <= '0;
			int_flag <= '0;
			IRQ_O <= 1'b0;
		end else begin
			int_en <= next_int_en;
			int_flag <= next_int_flag;
			IRQ_O <= next_irq;
		end
	end

	// Watchdog: enable is one-way so runaway code cannot switch it off
	always_comb begin
		next_wd_en = wd_en;
		next_wd_expired = wd_expired;
		next_wd_preload = wd_preload;
		next_wd_count = wd_count;
		next_key_state = key_state;
		if (wr_en && hit(PADDR_I, OFS_WD_PRELOAD)) next_wd_preload = PWDATA_I;
		if (wr_en && hit(PADDR_I, OFS_WD_KEY)) begin
			case (key_state)
				KEY_WAIT_FIRST: begin
					if (PWDATA_I[15:0] == WD_KEY_FIRST) begin
						next_key_state = KEY_WAIT_SECOND;
					end
				end
				KEY_WAIT_SECOND: begin
					if (PWDATA_I[15:0] == WD_KEY_SECOND) begin
						next_key_state = KEY_WAIT_FIRST;
						if (wd_en && !wd_expired) next_wd_count = wd_preload;
					end else if (PWDATA_I[15:0] != WD_KEY_FIRST) begin
						next_key_state = KEY_WAIT_FIRST;
					end
				end
				default: begin
					next_key_state = KEY_WAIT_FIRST;
				end
			endcase
		end
		if (wd_en && !wd_expired && (next_key_state == key_state ||
			key_state == KEY_WAIT_FIRST)) begin
			if (wd_count == RST_ZERO) begin
				next_wd_expired = 1'b1;
			end else begin
				next_wd_count = wd_count - 1'b1;
			end
		end
		if (!wd_en && wr_en && hit(PADDR_I, OFS_WD_CTRL) && PWDATA_I[0]) begin
			next_wd_en = 1'b1;
			next_wd_count = next_wd_preload;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			wd_en <= 1'b0;
			wd_expired <= 1'b0;
			wd_preload <= RST_WD_PRELOAD;
			wd_count <= RST_WD_PRELOAD;
			key_state <= KEY_WAIT_FIRST;
			WD_RESET_O <= 1'b0;
		end else begin
			wd_en <= next_wd_en;
			wd_expired <= next_wd_expired;
			wd_preload <= next_wd_preload;
			wd_count <= next_wd_count;
			key_state <= next_key_state;
			WD_RESET_O <= next_wd_expired;
		end
	end

	// Read decode; reserved and unmapped offsets answer with an error
	always_comb begin
		rd_mux = RST_ZERO;
		rd_ok = 1'b1;
		case (PADDR_I)
			OFS_GLOBAL_CTRL: rd_mux = DATA_W'(run);
			OFS_CAPTURE_CTRL: rd_mux = DATA_W'(cap_cnt_sel);
			OFS_COMPARE_CTRL: begin
				for (int i = 0; i < NUM_COMPARE; i++) begin
					rd_mux[i*COMPARE_SEL_STRIDE] = cmp_cnt_sel[i];
				end
			end
			OFS_INT_SET, OFS_INT_CLEAR: rd_mux = DATA_W'(int_en);
			OFS_INT_FLAG: rd_mux = DATA_W'(int_flag);
			OFS_WD_CTRL: rd_mux = DATA_W'(wd_en);
			OFS_WD_PRELOAD: rd_mux = wd_preload;
			OFS_WD_STATUS: begin
				rd_mux[WD_STAT_EXPIRED] = wd_expired;
				rd_mux[WD_STAT_ENABLED] = wd_en;
			end
			OFS_WD_KEY: rd_mux = RST_ZERO;
			OFS_WD_COUNT: rd_mux = wd_count;
			OFS_CAPTURE_SOURCE: begin
				rd_mux[CAPSEL0_LSB +: CAPSEL_W] = cap_src[0 +: CAPSEL_W];
				rd_mux[CAPSEL1_LSB +: CAPSEL_W] = cap_src[CAPSEL_W +: CAPSEL_W];
			end
			default: rd_ok = 1'b0;
		endcase
		for (int c = 0; c < NUM_COUNTER; c++) begin
			if (hit(PADDR_I, 12'(OFS_CNT_BASE + OFS_CNT_STRIDE * c) +
				OFS_FREE_RUN)) begin
				rd_mux = cnt_stat[c].free_run;
				rd_ok = 1'b1;
			end
			if (hit(PADDR_I, 12'(OFS_CNT_BASE + OFS_CNT_STRIDE * c) +
				OFS_PRESCALE_CNT)) begin
				rd_mux = cnt_stat[c].prescale;
				rd_ok = 1'b1;
			end
			if (hit(PADDR_I, 12'(OFS_CNT_BASE + OFS_CNT_STRIDE * c) +
				OFS_PRESCALE_CMP)) begin
				rd_mux = cnt_stat[c].prescale_cmp;
				rd_ok = 1'b1;
			end
			if (hit(PADDR_I, 12'(OFS_CNT_BASE + OFS_CNT_STRIDE * c) +
				OFS_CAPT_FREE)) begin
				rd_mux = cnt_stat[c].capt_free;
				rd_ok = 1'b1;
			end
			if (hit(PADDR_I, 12'(OFS_CNT_BASE + OFS_CNT_STRIDE * c) +
				OFS_CAPT_PRESCALE)) begin
				rd_mux = cnt_stat[c].capt_prescale;
				rd_ok = 1'b1;
			end
		end
		for (int i = 0; i < NUM_COMPARE; i++) begin
			if (hit(PADDR_I, 12'(OFS_COMPARE_BASE + OFS_COMPARE_STRIDE * i))) begin
				rd_mux = cmp_val[i];
				rd_ok = 1'b1;
			end
			if (hit(PADDR_I, 12'(OFS_INCREMENT_BASE + OFS_COMPARE_STRIDE * i))) begin
				rd_mux = cmp_inc[i];
				rd_ok = 1'b1;
			end
		end
	end

	// Answer sampled in setup, so every access completes in one cycle
	always_comb begin
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = RST_ZERO;
		if (PSEL_I && !PENABLE_I) begin
			next_pready = 1'b1;
			next_pslverr = !rd_ok;
			next_prdata = (rd_ok && !PWRITE_I) ? rd_mux : RST_ZERO;
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= RST_ZERO;
		end else begin
			PREADY_O <= next_pready;
			PSLVERR_O <= next_pslverr;
			PRDATA_O <= next_prdata;
		end
	end
endmodule : periodic_interrupt_timer
`default_nettype wire

// ===== test/periodic_interrupt_timer_props.sv
// Purpose: Port-level properties of the periodic interrupt timer.
// Assumes: One clock domain; APB answers one cycle after setup.
// Notes: Helper logic follows preload and service points of the watchdog.
`timescale 1ns/1ps
`default_nettype none
module pit_props import timer_pkg::*; (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	// APB slave side
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [DATA_W-1:0] PWDATA_I,
	input wire logic [DATA_W-1:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// Events and outputs
	input wire logic [NUM_DMA_EVENTS-1:0] DMA_EVENT_I,
	input wire logic IRQ_O,
	input wire logic WD_RESET_O
);
	logic wr_ok, en_seen, next_en_seen, key_half, next_key_half;
	logic [31:0] pre, next_pre, svc, next_svc, ld, next_ld;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	// Accepted write at its completing edge
	assign wr_ok = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && !PSLVERR_O;

	// Service tracking; a lone second key must not count as a reload
	always_comb begin
		next_en_seen = en_seen;
		next_key_half = key_half;
		next_pre = pre;
		next_ld = ld;
		next_svc = svc + 32'h1;
		// Span is the preload taken at the load point, not a later write
		if (wr_ok && PADDR_I == OFS_WD_CTRL && PWDATA_I[0]) begin
			next_en_seen = 1'b1;
			next_svc = 32'h0;
			next_ld = pre;
		end
		if (wr_ok && PADDR_I == OFS_WD_PRELOAD)
			next_pre = PWDATA_I;
		if (wr_ok && PADDR_I == OFS_WD_KEY) begin
			next_key_half = PWDATA_I[15:0] == WD_KEY_FIRST;
			if (key_half && PWDATA_I[15:0] == WD_KEY_SECOND) begin
				next_svc = 32'h0;
				next_ld = pre;
			end
		end
	end

	// Helper registers
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			en_seen <= 1'b0;
			key_half <= 1'b0;
			pre <= RST_WD_PRELOAD;
			ld <= RST_WD_PRELOAD;
			svc <= 32'h0;
		end else begin
			en_seen <= next_en_seen;
			key_half <= next_key_half;
			pre <= next_pre;
			ld <= next_ld;
			svc <= next_svc;
		end
	end

	property p_ready; PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O; endproperty
	a_ready: assert property (p_ready)
		else $error("ready is not one cycle after setup");
	property p_idle; !PREADY_O |-> PRDATA_O == 32'h0 && !PSLVERR_O; endproperty
	a_idle: assert property (p_idle)
		else $error("answer outputs not cleared when idle");
	property p_rsv;
		PSEL_I && !PENABLE_I && PADDR_I inside {12'h004, 12'h070} |=>
			PSLVERR_O && PRDATA_O == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved offset not refused");
	property p_key_rd;
		PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == OFS_WD_KEY |=>
			PRDATA_O == 32'h0;
	endproperty
	a_key_rd: assert property (p_key_rd)
		else $error("key register read not zero");
	property p_wd_off; !en_seen |-> !WD_RESET_O; endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("watchdog reset while never enabled");
	property p_wd_hold; WD_RESET_O |=> WD_RESET_O; endproperty
	a_wd_hold: assert property (p_wd_hold)
		else $error("watchdog reset dropped");
	property p_wd_span; $rose(WD_RESET_O) |-> svc > ld; endproperty
	a_wd_span: assert property (p_wd_span)
		else $error("watchdog expired before preload span");
	property p_irq_fall;
		$fell(IRQ_O) |-> $past(PSEL_I) && $past(PWRITE_I);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("interrupt fell without a write");
endmodule : pit_props

bind periodic_interrupt_timer pit_props u_props (.CLK_I(CLK_I),
	.ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.DMA_EVENT_I(DMA_EVENT_I), .IRQ_O(IRQ_O), .WD_RESET_O(WD_RESET_O));
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench for the periodic interrupt timer.
// Assumes: APB answers one cycle after setup; all inputs bench driven.
// Notes: Counter spans sit mid-period so one cycle of skew cannot flip them.
`timescale 1ns/1ps
`default_nettype none
module tb import timer_pkg::*;;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, wd_rst;
	logic err;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, q, r0, r1, inc;
	logic [NUM_DMA_EVENTS-1:0] dma;
	int num_errors = 0;
	int total_checks = 0;
	int t0, p, e0, e1;

	periodic_interrupt_timer DUT (.CLK_I(clk), .ARST_N_I(arst_n),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .DMA_EVENT_I(dma),
		.IRQ_O(irq), .WD_RESET_O(wd_rst));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic tally_and_finish;
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// One transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Waits for the answer; only the hang guard ends a stuck wait
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		check(32'(n), 32'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
		check({31'h0, err}, 32'h0);
	endtask : rd

	// One-cycle pulse on the DMA event lines
	task automatic pulse(input logic [5:0] v);
		@(posedge clk);
		dma <= v;
		@(posedge clk);
		dma <= 6'h0;
	endtask : pulse

	function automatic logic [11:0] cnt_a(input int c, input logic [11:0] o);
		return OFS_CNT_BASE + 12'(c) * OFS_CNT_STRIDE + o;
	endfunction : cnt_a

	function automatic logic [11:0] cmp_a(input int i);
		return OFS_COMPARE_BASE + 12'(i) * OFS_COMPARE_STRIDE;
	endfunction : cmp_a

	function automatic logic [31:0] fr_exp(input int span, input int cmp);
		return 32'(span / (cmp + 1));
	endfunction : fr_exp

	// Hang guard, far beyond the expected run length
	initial begin
		#(50 * 20000);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		{psel, penable, pwrite, arst_n} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		dma = 6'h0;
		void'($urandom(52893));
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		// Reset values, key readback, refused reserved offsets
		rd(OFS_WD_PRELOAD, RST_WD_PRELOAD);
		rd(OFS_WD_COUNT, RST_WD_PRELOAD);
		rd(OFS_WD_STATUS, RST_ZERO);
		rd(OFS_INT_SET, RST_ZERO);
		rd(OFS_WD_KEY, RST_ZERO);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, k ? 12'h070 : 12'h004, 32'hFFFF_FFFF);
			check({31'h0, err}, 32'h1);
		end
		// Each counter alone, own ratio; the other stays put
		wr(cnt_a(0, OFS_PRESCALE_CMP), 32'h4);
		wr(cnt_a(1, OFS_PRESCALE_CMP), 32'h7);
		for (int c = 0; c < 2; c++) begin
			wr(OFS_GLOBAL_CTRL, 32'(1 << c));
			repeat (40) @(posedge clk);
			wr(OFS_GLOBAL_CTRL, 32'h0);
			rd(cnt_a(c, OFS_FREE_RUN), fr_exp(43, c ? 7 : 4));
			rd(cnt_a(1 - c, OFS_FREE_RUN), c ? 32'h8 : 32'h0);
		end
		// Every compare unit; odd ones watch counter 1
		wr(OFS_COMPARE_CTRL, 32'h0000_1010);
		for (int i = 0; i < NUM_COMPARE; i++) begin
			inc = 32'd10 + ($urandom % 16);
			wr(cnt_a(i % 2, OFS_PRESCALE_CMP), 32'h0);
			wr(cnt_a(i % 2, OFS_FREE_RUN), 32'h0);
			wr(cmp_a(i), 32'd20);
			wr(cmp_a(i) + 12'h4, inc);
			wr(OFS_INT_SET, 32'(1 << i));
			wr(OFS_GLOBAL_CTRL, 32'(1 << (i % 2)));
			for (t0 = 0; irq !== 1'b1 && t0 < 100; t0++)
				@(posedge clk);
			check({31'h0, irq}, 32'h1);
			wr(OFS_GLOBAL_CTRL, 32'h0);
			rd(cmp_a(i), 32'd20 + inc);
			rd(OFS_INT_FLAG, 32'(1 << i));
			wr(OFS_INT_CLEAR, 32'(1 << i));
			@(posedge clk);
			check({31'h0, irq}, 32'h0);
			rd(OFS_INT_SET, 32'h0);
			wr(OFS_INT_FLAG, 32'(1 << i));
		end
		// Captures: stray lines ignored, chosen lines latch still counters
		e0 = $urandom % 6;
		e1 = (e0 + 1 + $urandom % 5) % 6;
		r0 = $urandom;
		r1 = $urandom;
		wr(OFS_CAPTURE_SOURCE, 32'(e0 | (e1 << CAPSEL1_LSB)));
		wr(OFS_CAPTURE_CTRL, 32'h2);
		wr(cnt_a(0, OFS_FREE_RUN), r0);
		wr(cnt_a(1, OFS_FREE_RUN), r1);
		wr(cnt_a(0, OFS_PRESCALE_CNT), 32'h1);
		wr(cnt_a(1, OFS_PRESCALE_CNT), 32'h2);
		pulse(~(6'(1 << e0) | 6'(1 << e1)));
		rd(OFS_INT_FLAG, 32'h0);
		pulse(6'(1 << e0));
		pulse(6'(1 << e1));
		rd(OFS_INT_FLAG, 32'h30);
		rd(cnt_a(0, OFS_CAPT_FREE), r0);
		rd(cnt_a(0, OFS_CAPT_PRESCALE), 32'h1);
		rd(cnt_a(1, OFS_CAPT_FREE), r1);
		rd(cnt_a(1, OFS_CAPT_PRESCALE), 32'h2);
		// Watchdog kept alive past its span, then starved by bad keys
		p = 30 + $urandom % 31;
		wr(OFS_WD_PRELOAD, 32'(p));
		wr(OFS_WD_CTRL, 32'h1);
		rd(OFS_WD_STATUS, 32'h2);
		for (int k = 0; k < 4; k++) begin
			repeat (p - 12) @(posedge clk);
			wr(OFS_WD_KEY, 32'(WD_KEY_FIRST));
			wr(OFS_WD_KEY, 32'(WD_KEY_SECOND));
		end
		t0 = $time;
		check({31'h0, wd_rst}, 32'h0);
		wr(OFS_WD_KEY, 32'(WD_KEY_SECOND));
		wr(OFS_WD_KEY, 32'(WD_KEY_FIRST));
		while (wd_rst !== 1'b1 && $time - t0 < 50 * 200)
			@(posedge clk);
		check(32'(($time - t0) / 50), 32'(p + 2));
		repeat (5) @(posedge clk);
		check({31'h0, wd_rst}, 32'h1);
		rd(OFS_WD_STATUS, 32'h3);
		// Second reset in mid-run clears the latched expiry
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		check({31'h0, wd_rst}, 32'h0);
		rd(OFS_WD_STATUS, 32'h0);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
